// File: core/sbs_top.sv
// Purpose: status compare and brake sequencing of a servo drive
// Assumes: i_update marks a control sample; inputs synchronous to i_sys_clk
// Notes:   o_brake_control_out high means the holding brake is engaged
`timescale 1ns/10ps
`default_nettype none
`include "sbs_defs.svh"
module sbs_top #(
  parameter int MS_CYC = `SBS_MS_CYC
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // register port
  input  wire logic [7:0]        i_addr,
  input  wire logic [15:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [15:0]       o_rdata,
  // measurements
  input  wire logic              i_update,
  input  wire sbs_pkg::sbs_meas_t i_meas,
  // status outputs
  output logic                   o_positioning_done_out,
  output logic                   o_speed_match_out,
  output logic                   o_zero_clamp,
  output logic                   o_rotation_detected,
  output logic                   o_overflow_alarm,
  output logic signed [31:0]     o_torque_ref,
  // filter enables
  output logic                   o_notch1_en,
  output logic                   o_notch2_en,
  output logic                   o_lowfreq_vib_en,
  // brake sequencing
  output logic                   o_brake_control_out,
  output logic                   o_excitation,
  // interrupt
  output logic                   o_irq
);
  typedef enum logic [1:0] {ST_OFF, ST_ON_WAIT, ST_ON, ST_OFF_WAIT} sbs_st_t;

  logic [15:0] cfg_q [`SBS_NUM_CFG];
  sbs_st_t st_q, st_d;
  sbs_pkg::sbs_evt_t evt_q, evt_d, ist_q, msk_q;
  logic [31:0] pre_q;
  logic [15:0] ms_q;
  logic son_q, brk_q, brk_d, exc_q, exc_d, zc_q, rot_q, pd_q, vm_q, ov_q;
  logic signed [31:0] tref_q;
  logic [15:0] rdata_q;
  logic irq_q, n1_q, n2_q, lv_q;

  // register decode
  wire [4:0]  w_ix    = i_addr[6:2];
  wire        w_cfg   = (i_addr[1:0] == 2'h0) && (i_addr[7:2] < 6'(`SBS_NUM_CFG));
  wire        w_wcfg  = i_wr && w_cfg;
  wire        w_wclr  = i_wr && (i_addr == `SBS_A_IRQ_ST);
  wire        w_wmsk  = i_wr && (i_addr == `SBS_A_IRQ_MSK);
  wire sbs_pkg::sbs_mode_t w_mode = sbs_pkg::sbs_mode_t'(cfg_q[`SBS_IX_CTRL][1:0]);
  wire        w_son   = cfg_q[`SBS_IX_CTRL][`SBS_CTRL_SON];
  wire        w_bkasg = cfg_q[`SBS_IX_CTRL][`SBS_CTRL_BKASG];

  // magnitudes; a 17-bit difference avoids wrap on opposite signs
  wire signed [16:0] w_vdiff = 17'(i_meas.speed_ref) - 17'(i_meas.speed_fb);
  wire [16:0] w_vgap  = w_vdiff[16] ? 17'(-w_vdiff) : w_vdiff;
  wire [15:0] w_fbabs = i_meas.speed_fb[15] ? 16'(-i_meas.speed_fb) : i_meas.speed_fb;
  wire [15:0] w_asabs = i_meas.analog_speed[15] ? 16'(-i_meas.analog_speed)
                                                : i_meas.analog_speed;
  wire [23:0] w_peabs = i_meas.pos_err[23] ? 24'(-i_meas.pos_err) : i_meas.pos_err;
  wire [23:0] w_othr  = {cfg_q[`SBS_IX_OTHR], 8'h00};

  // compare results
  wire w_pd  = (w_mode == sbs_pkg::SBS_POS) && (w_peabs < 24'(cfg_q[`SBS_IX_PTHR]));
  wire w_vm  = w_vgap < 17'(cfg_q[`SBS_IX_VTHR]);
  wire w_zc  = (w_mode == sbs_pkg::SBS_SPD) && (w_asabs < cfg_q[`SBS_IX_ZTHR]);
  wire w_rot = w_fbabs > cfg_q[`SBS_IX_RTHR];
  wire w_ov  = (w_mode == sbs_pkg::SBS_POS) && (w_peabs > w_othr);

  // torque reference, signed product of biased voltage and gain
  wire signed [16:0] w_tdiff = 17'(i_meas.analog_volt) - 17'($signed(cfg_q[`SBS_IX_TZB]));
  wire signed [33:0] w_tprod = w_tdiff * $signed({1'b0, cfg_q[`SBS_IX_TGN]});
  wire signed [31:0] w_tref  = (w_mode == sbs_pkg::SBS_TRQ) ? w_tprod[31:0] : 32'sh0;

  // brake timing helpers
  wire signed [15:0] w_sonw = $signed(cfg_q[`SBS_IX_SONW]);
  wire [15:0] w_sonmag = w_sonw[15] ? 16'(-w_sonw) : w_sonw;
  wire        w_on_rise = w_son && !son_q;
  wire        w_on_fall = !w_son && son_q;
  wire        w_wait_done = ms_q >= w_sonmag;
  wire        w_bk_spd = w_fbabs < cfg_q[`SBS_IX_BSPD];
  wire        w_bk_tim = ms_q > cfg_q[`SBS_IX_BTIM];
  wire        w_ms_tick = pre_q == 32'(MS_CYC - 1);
  wire        w_cnt_clr = (st_d != st_q);

  // brake sequencer next state
  always_comb begin
    st_d  = st_q;
    brk_d = brk_q;
    exc_d = exc_q;
    case (st_q)
      ST_OFF: begin
        if (w_on_rise && !w_bkasg) begin
          st_d  = ST_ON;
          brk_d = 1'b0;
          exc_d = 1'b1;
        end else if (w_on_rise && !w_sonw[15]) begin
          st_d  = ST_ON_WAIT;
          brk_d = 1'b0;
          exc_d = 1'b0;
        end else if (w_on_rise) begin
          st_d  = ST_ON_WAIT;
          brk_d = 1'b1;
          exc_d = 1'b1;
        end
      end
      ST_ON_WAIT: begin
        if (!w_son) begin
          st_d  = ST_OFF;
          brk_d = 1'b1;
          exc_d = 1'b0;
        end else if (w_wait_done) begin
          st_d  = ST_ON;
          brk_d = 1'b0;
          exc_d = 1'b1;
        end
      end
      ST_ON: begin
        if (w_on_fall) begin
          exc_d = 1'b0;
          if (!w_bkasg || cfg_q[`SBS_IX_FLOW] == 16'h0000) begin
            st_d  = ST_OFF;
            brk_d = 1'b1;
          end else begin
            st_d = ST_OFF_WAIT;
          end
        end
      end
      ST_OFF_WAIT: begin
        if (w_bk_spd || w_bk_tim || !w_bkasg) begin
          st_d  = ST_OFF;
          brk_d = 1'b1;
        end
      end
      default: begin
        st_d  = ST_OFF;
        brk_d = 1'b1;
        exc_d = 1'b0;
      end
    endcase
  end

  // events: rising edge of each status except zero clamp, plus brake engage; set wins over a clear
  assign evt_d = '{brake: brk_d && !brk_q, ovf: w_ov, rot: w_rot, vmatch: w_vm, pdone: w_pd};
  // brake engage is already an edge, so it is never masked by the last update's copy
  wire sbs_pkg::sbs_evt_t w_rise = {evt_d.brake,
                                    i_update ? (evt_d[3:0] & ~evt_q[3:0]) : 4'h0};
  wire sbs_pkg::sbs_evt_t w_clr  = w_wclr ? sbs_pkg::sbs_evt_t'(i_wdata[4:0]) : '0;
  wire sbs_pkg::sbs_evt_t w_ist  = (ist_q & ~w_clr) | w_rise;

  // read mux
  wire [15:0] w_rd_v =
    w_cfg                        ? cfg_q[w_ix] :
    (i_addr == `SBS_A_STATUS)    ? {9'h000, st_q, pd_q, vm_q, zc_q, rot_q, ov_q} :
    (i_addr == `SBS_A_IRQ_ST)    ? {11'h000, ist_q} :
    (i_addr == `SBS_A_IRQ_MSK)   ? {11'h000, msk_q} :
    (i_addr == `SBS_A_TREF_LO)   ? tref_q[15:0] :
    (i_addr == `SBS_A_TREF_HI)   ? tref_q[31:16] : 16'h0000;

  // configuration words; notch frequencies reset to bypass
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < `SBS_NUM_CFG; k++) begin
        cfg_q[k] <= (k == 1 || k == 3) ? `SBS_NOTCH_OFF : 16'h0000;
      end
    end else if (w_wcfg) begin
      cfg_q[w_ix] <= i_wdata;
    end
  end

  // compare outputs refresh on each update with live settings
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {pd_q, vm_q, zc_q, rot_q, ov_q} <= 5'h00;
      tref_q <= 32'sh0;
      evt_q  <= '0;
    end else if (i_update) begin
      {pd_q, vm_q, zc_q, rot_q, ov_q} <= {w_pd, w_vm, w_zc, w_rot, w_ov};
      tref_q <= w_tref;
      evt_q  <= evt_d;
    end
  end

  // filter enables follow their settings every cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {n1_q, n2_q, lv_q} <= 3'h0;
    end else begin
      n1_q <= cfg_q[`SBS_IX_N1F] != `SBS_NOTCH_OFF;
      n2_q <= cfg_q[`SBS_IX_N2F] != `SBS_NOTCH_OFF;
      lv_q <= (w_mode == sbs_pkg::SBS_POS) || (w_mode == sbs_pkg::SBS_SPD);
    end
  end

  // sequencer state and millisecond timer, restarted on each state change
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q  <= ST_OFF;
      brk_q <= 1'b1;
      exc_q <= 1'b0;
      son_q <= 1'b0;
      pre_q <= 32'h0;
      ms_q  <= 16'h0000;
    end else begin
      st_q  <= st_d;
      brk_q <= brk_d;
      exc_q <= exc_d;
      son_q <= w_son;
      pre_q <= (w_cnt_clr || w_ms_tick) ? 32'h0 : pre_q + 32'h1;
      if (w_cnt_clr) begin
        ms_q <= 16'h0000;
      end else if (w_ms_tick && ms_q != 16'hFFFF) begin
        ms_q <= ms_q + 16'h0001; // saturates rather than wraps
      end
    end
  end

  // interrupt status, mask, read data
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ist_q   <= '0;
      msk_q   <= '0;
      irq_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ist_q   <= w_ist;
      msk_q   <= w_wmsk ? sbs_pkg::sbs_evt_t'(i_wdata[4:0]) : msk_q;
      irq_q   <= |(w_ist & (w_wmsk ? sbs_pkg::sbs_evt_t'(i_wdata[4:0]) : msk_q));
      rdata_q <= i_rd ? w_rd_v : 16'h0000;
    end
  end

  assign o_rdata                = rdata_q;
  assign o_positioning_done_out = pd_q;
  assign o_speed_match_out      = vm_q;
  assign o_zero_clamp           = zc_q;
  assign o_rotation_detected    = rot_q;
  assign o_overflow_alarm       = ov_q;
  assign o_torque_ref           = tref_q;
  assign o_notch1_en            = n1_q;
  assign o_notch2_en            = n2_q;
  assign o_lowfreq_vib_en       = lv_q;
  assign o_brake_control_out    = brk_q;
  assign o_excitation           = exc_q;
  assign o_irq                  = irq_q;

  // checks
  chk_notch_bypass: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cfg_q[`SBS_IX_N1F] == `SBS_NOTCH_OFF |=> !o_notch1_en)
    else $error("notch 1 not bypassed at 5000");
  chk_lowfreq_mode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    w_mode == sbs_pkg::SBS_TRQ |=> !o_lowfreq_vib_en)
    else $error("low-frequency suppression on in torque mode");
  chk_torque_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_update && w_mode != sbs_pkg::SBS_TRQ |=> o_torque_ref == 32'sh0)
    else $error("torque reference outside torque mode");
  chk_pos_done: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_update && w_mode == sbs_pkg::SBS_POS && w_peabs >= 24'(cfg_q[`SBS_IX_PTHR])
    |=> !o_positioning_done_out)
    else $error("positioning done with error at threshold");
  chk_speed_match: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_update |=> o_speed_match_out == $past(w_vgap < 17'(cfg_q[`SBS_IX_VTHR])))
    else $error("speed match wrong");
  chk_zero_clamp: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_update && w_mode != sbs_pkg::SBS_SPD |=> !o_zero_clamp)
    else $error("zero clamp outside speed mode");
  chk_overflow_thr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_update
    |=> o_overflow_alarm == $past((w_mode == sbs_pkg::SBS_POS) && (w_peabs > w_othr)))
    else $error("overflow alarm does not follow threshold");
  chk_sonw_pos: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q == ST_ON_WAIT && !w_sonw[15] && w_bkasg |-> !o_brake_control_out && !o_excitation)
    else $error("non-negative wait order wrong");
  chk_sonw_neg: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q == ST_ON_WAIT && w_sonw[15] |-> o_brake_control_out && o_excitation)
    else $error("negative wait order wrong");
  chk_std_flow: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q == ST_ON && w_on_fall && cfg_q[`SBS_IX_FLOW] == 16'h0000
    |=> o_brake_control_out && !o_excitation)
    else $error("brake and servo-off not together");
  chk_brake_either: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q == ST_OFF_WAIT && (w_bk_spd || w_bk_tim) |=> o_brake_control_out)
    else $error("brake late after servo-off");
  chk_rotation_thr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_update |=> o_rotation_detected == $past(w_fbabs > cfg_q[`SBS_IX_RTHR]))
    else $error("rotation detected wrong");
  chk_zero_clamp_on: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_update && w_mode == sbs_pkg::SBS_SPD && w_asabs < cfg_q[`SBS_IX_ZTHR] |=> o_zero_clamp)
    else $error("zero clamp missing below threshold");
  chk_brake_unassigned: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q == ST_OFF && w_on_rise && !w_bkasg |=> !o_brake_control_out && o_excitation)
    else $error("unassigned brake still timed");
  chk_brake_speed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q == ST_OFF_WAIT && w_bk_spd |=> o_brake_control_out)
    else $error("brake late below wait speed");
  chk_brake_time: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q == ST_OFF_WAIT && w_bk_tim |=> o_brake_control_out)
    else $error("brake late after wait time");
  chk_brake_event: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    brk_d && !brk_q |=> ist_q.brake)
    else $error("brake engage event lost");
endmodule
`default_nettype wire

// File: inc/sbs_defs.svh
// Purpose: offsets, field positions, reset values and timing for the servo status block
// Assumes: 16-bit register port, byte offsets, one word per register
// Notes:   configuration words sit at 4*index, status words above them
// Behaviour
// - Two notch filters have a frequency and a depth each, and a frequency of 5000 bypasses one.
// - Low-frequency vibration frequency (0.1 Hz units) and damping apply only in position and speed modes.
// - In torque mode the torque reference is (input voltage minus zero bias) times the input gain.
// - In position mode positioning done is high while the position error is below its threshold.
// - Speed match is high while the gap between speed reference and feedback is below its threshold.
// - In speed mode zero clamp is held while the analog speed command is below its threshold.
// - In every mode rotation detected is high while motor speed exceeds its threshold.
// - Brake timing settings act only while the brake output is assigned to a terminal.
// - A non-negative servo-on wait releases the brake at once and excites the motor after the wait.
// - A negative servo-on wait excites at once and releases the brake after the wait magnitude.
// - The standard basic flow engages the brake and removes excitation in the same cycle.
// - After servo-off the brake engages once motor speed falls below the brake wait speed.
// - After servo-off the brake engages once the time since servo-off exceeds the brake wait time.
// - After servo-off the brake engages on whichever of speed or time is met first.
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH
`define SBS_IX_CTRL    5'd0
`define SBS_IX_N1F     5'd1
`define SBS_IX_N1D     5'd2
`define SBS_IX_N2F     5'd3
`define SBS_IX_N2D     5'd4
`define SBS_IX_LVF     5'd5
`define SBS_IX_LVD     5'd6
`define SBS_IX_TZB     5'd7
`define SBS_IX_TGN     5'd8
`define SBS_IX_PTHR    5'd9
`define SBS_IX_VTHR    5'd10
`define SBS_IX_ZTHR    5'd11
`define SBS_IX_RTHR    5'd12
`define SBS_IX_OTHR    5'd13
`define SBS_IX_SONW    5'd14
`define SBS_IX_FLOW    5'd15
`define SBS_IX_BSPD    5'd16
`define SBS_IX_BTIM    5'd17
`define SBS_NUM_CFG    18
`define SBS_A_STATUS   8'h60
`define SBS_A_IRQ_ST   8'h64
`define SBS_A_IRQ_MSK  8'h68
`define SBS_A_TREF_LO  8'h6C
`define SBS_A_TREF_HI  8'h70
`define SBS_CTRL_SON   2
`define SBS_CTRL_BKASG 3
`define SBS_NOTCH_OFF  16'd5000
`define SBS_OVF_SHIFT  8
`define SBS_CLK_NS     50
`define SBS_MS_NS      1000000
`define SBS_MS_CYC     (`SBS_MS_NS / `SBS_CLK_NS)
`endif

// File: inc/sbs_pkg.sv
// Purpose: types shared by the servo status block
// Assumes: nothing beyond the defs header
// Notes:   measurements travel as one packed struct
package sbs_pkg;
  typedef enum logic [1:0] {
    SBS_POS, SBS_SPD, SBS_TRQ, SBS_RSV
  } sbs_mode_t;
  typedef struct packed {
    logic signed [23:0] pos_err;
    logic signed [15:0] speed_ref;
    logic signed [15:0] speed_fb;
    logic signed [15:0] analog_speed;
    logic signed [15:0] analog_volt;
  } sbs_meas_t;
  typedef struct packed {
    logic brake;
    logic ovf;
    logic rot;
    logic vmatch;
    logic pdone;
  } sbs_evt_t;
endpackage

// File: tb/sbs_motor_model.sv
// Purpose: motor shaft and holding brake driven by the sequencer outputs
// Assumes: shaft follows the run speed while excited and released
// Notes:   a free shaft coasts down one unit a cycle, so speed and time exits differ
`timescale 1ns/10ps
`default_nettype none
module sbs_motor_model (
  // clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  // drive side
  input  wire logic               i_excitation,
  input  wire logic               i_brake,
  input  wire logic signed [15:0] i_run_speed,
  // feedback
  output logic signed [15:0]      o_speed_fb
);
  logic signed [15:0] speed_q;
  // engaged brake stops the shaft at once; slow coast keeps the speed exit late
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) speed_q <= 16'sh0000;
    else if (i_brake) speed_q <= 16'sh0000;
    else if (i_excitation) speed_q <= i_run_speed;
    else if (speed_q > 16'sh0000) speed_q <= speed_q - 16'sh0001;
  end
  assign o_speed_fb = speed_q;
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: register, compare and brake sequence tests of the servo status block
// Assumes: short ms timer (4 cycles) so brake waits stay brief
// Notes:   speed feedback comes from the motor model during brake tests
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int MSC = 4;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_update = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000, d;
  logic [15:0] o_rdata;
  sbs_pkg::sbs_meas_t meas_r = '0, meas_w;
  logic o_pd, o_vm, o_zc, o_rot, o_ovf, o_n1, o_n2, o_lf, o_brk, o_exc, o_irq;
  logic signed [31:0] o_tref;
  logic signed [15:0] run_speed = 16'sh0000, spd;
  logic use_mdl = 1'b0;
  int bad_count = 0, n_checks = 0, k;
  // free-running 20 MHz clock
  always #25 i_sys_clk = ~i_sys_clk;
  // model speed replaces measured feedback only when asked
  always_comb begin
    meas_w = meas_r;
    if (use_mdl) meas_w.speed_fb = spd;
  end
  sbs_top #(.MS_CYC(MSC)) dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_update(i_update), .i_meas(meas_w),
    .o_positioning_done_out(o_pd), .o_speed_match_out(o_vm), .o_zero_clamp(o_zc),
    .o_rotation_detected(o_rot), .o_overflow_alarm(o_ovf), .o_torque_ref(o_tref),
    .o_notch1_en(o_n1), .o_notch2_en(o_n2), .o_lowfreq_vib_en(o_lf),
    .o_brake_control_out(o_brk), .o_excitation(o_exc), .o_irq(o_irq));
  sbs_motor_model mdl (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_excitation(o_exc), .i_brake(o_brk),
    .i_run_speed(run_speed), .o_speed_fb(spd));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1;
    v = o_rdata;
  endtask
  task automatic upd(input int pe, input int sr, input int sf, input int az, input int av);
    @(posedge i_sys_clk);
    i_update <= 1'b1;
    meas_r   <= {pe[23:0], sr[15:0], sf[15:0], az[15:0], av[15:0]};
    @(posedge i_sys_clk);
    i_update <= 1'b0;
    #1;
  endtask
  // bounded wait on brake (brk=1) or excitation level
  task automatic wt(input bit brk, input logic v, input int n, output int c);
    c = 0;
    #1;
    while (((brk ? o_brk : o_exc) !== v) && c < n) begin
      @(posedge i_sys_clk);
      #1;
      c++;
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles of the tests
  initial begin
    #(20000 * 50);
    bad_count++;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    // notch bypass at 5000
    rd(8'h04, d);
    chk(d, 16'h1388);
    chk(o_n1, 1'b0);
    wr(8'h04, 16'h0064);
    wr(8'h0C, 16'h00C8);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk({o_n1, o_n2}, 2'b11);
    wr(8'h0C, 16'h1388);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk(o_n2, 1'b0);
    chk(o_lf, 1'b1);
    // position compares and interrupt
    wr(8'h24, 16'h000A);
    wr(8'h34, 16'h0002);
    wr(8'h64, 16'h001F);
    wr(8'h68, 16'h0001);
    upd(513, 0, 0, 0, 0);
    chk({o_pd, o_ovf}, 2'b01);
    upd(512, 0, 0, 0, 0);
    chk(o_ovf, 1'b0);
    upd(9, 0, 0, 0, 0);
    chk(o_pd, 1'b1);
    chk(o_irq, 1'b1);
    wr(8'h64, 16'h0001);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk(o_irq, 1'b0);
    rd(8'h5C, d);
    chk(d, 16'h0000);
    wr(8'h24, 16'h0009);
    upd(9, 0, 0, 0, 0);
    chk(o_pd, 1'b0);
    upd(-8, 0, 0, 0, 0);
    chk(o_pd, 1'b1);
    // speed match and rotation
    wr(8'h28, 16'h0005);
    wr(8'h30, 16'h0032);
    upd(0, 100, 96, 0, 0);
    chk({o_vm, o_rot}, 2'b11);
    rd(8'h60, d);
    chk(d, 16'h001A);
    upd(0, 100, 95, 0, 0);
    chk(o_vm, 1'b0);
    upd(0, 0, 50, 0, 0);
    chk(o_rot, 1'b0);
    // zero clamp in speed mode
    wr(8'h00, 16'h0001);
    wr(8'h2C, 16'h0014);
    upd(0, 0, 0, 19, 0);
    chk({o_zc, o_lf}, 2'b11);
    upd(0, 0, 0, 20, 0);
    chk(o_zc, 1'b0);
    // torque reference
    wr(8'h00, 16'h0002);
    wr(8'h1C, 16'h0064);
    wr(8'h20, 16'h0003);
    upd(0, 0, 60, 0, 1100);
    chk(o_tref, 32'h00000BB8);
    rd(8'h6C, d);
    chk(d, 16'h0BB8);
    rd(8'h70, d);
    chk(d, 16'h0000);
    chk({o_rot, o_lf}, 2'b10);
    upd(0, 0, 0, 0, 40);
    chk(o_tref, 32'hFFFFFF4C);
    wr(8'h00, 16'h0000);
    upd(0, 0, 0, 0, 1100);
    chk(o_tref, 32'h00000000);
    // brake sequencing against the motor model
    use_mdl <= 1'b1;
    run_speed <= 16'sd1000;
    wr(8'h38, 16'h0003);
    wr(8'h00, 16'h0004);
    wt(0, 1'b1, 20, k);
    chk({k <= 2, o_brk}, 2'b10);
    wr(8'h00, 16'h0000);
    wt(1, 1'b1, 20, k);
    chk({k <= 2, o_exc}, 2'b10);
    wr(8'h00, 16'h000C);
    wt(1, 1'b0, 5, k);
    chk(o_exc, 1'b0);
    wt(0, 1'b1, 40, k);
    chk(k >= 9 && k <= 16, 1'b1);
    wr(8'h00, 16'h0008);
    wt(0, 1'b0, 5, k);
    chk(o_brk, 1'b1);
    wr(8'h38, 16'hFFFE);
    wr(8'h00, 16'h000C);
    wt(0, 1'b1, 5, k);
    chk({k <= 2, o_brk}, 2'b11);
    wt(1, 1'b0, 40, k);
    chk(k >= 6 && k <= 12, 1'b1);
    wr(8'h3C, 16'h0001);
    wr(8'h40, 16'h001E);
    wr(8'h44, 16'h0002);
    wr(8'h00, 16'h0008);
    wt(0, 1'b0, 5, k);
    chk(o_brk, 1'b0);
    wt(1, 1'b1, 40, k);
    chk(k >= 9 && k <= 16, 1'b1);
    wr(8'h44, 16'h0064);
    wr(8'h38, 16'h0000);
    run_speed <= 16'sd200;
    wr(8'h00, 16'h000C);
    wt(0, 1'b1, 10, k);
    repeat (3) @(posedge i_sys_clk);
    wr(8'h00, 16'h0008);
    wt(0, 1'b0, 5, k);
    wt(1, 1'b1, 400, k);
    chk(k >= 160 && k <= 180, 1'b1);
    chk(spd < 16'sd30, 1'b1);
    wrap_up;
  end
endmodule
`default_nettype wire
